// *** srt_top.sv ***
// Seconds clock with tick regulator, alarm and power-down control
//
// The implementer's own choices: register access over APB and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "srt_cfg.svh"

module srt_top
  import srt_pkg::*;
#(
  parameter int SETTLE_CYC = `SRT_SETTLE_CYC
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Asynchronous pins
  input wire logic clk_32k,
  input wire logic hib_reset_n,
  input wire logic wdt_reset_n,
  input wire logic main_power_lost,
  // Outputs
  output logic main_power_on_output,
  output logic rtc_irq
);

  localparam logic [31:0] SETTLE_LAST = 32'(SETTLE_CYC - 1);
  localparam logic [31:0] CTRL_RST = `SRT_CTRL_RST;

  // Pin synchronisers
  // Pins come from other domains; only the second stage reads the first stage
  logic [3:0] pin_in;
  logic [3:0] sync1_r;
  logic [3:0] sync2_r;
  logic clk32_d_r;
  logic edge32;
  logic hib_rst;
  logic wdt_rst;
  logic pwr_lost;

  assign pin_in = {main_power_lost, ~wdt_reset_n, ~hib_reset_n, clk_32k};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_sync
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          sync1_r[gi] <= 1'b0;
          sync2_r[gi] <= 1'b0;
        end else begin
          sync1_r[gi] <= pin_in[gi];
          sync2_r[gi] <= sync1_r[gi];
        end
      end
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk32_d_r <= 1'b0;
    end else begin
      clk32_d_r <= sync2_r[0];
    end
  end

  // Slow clock edge is seen two to three bus cycles late
  assign edge32 = sync2_r[0] & ~clk32_d_r;
  assign hib_rst = sync2_r[1];
  assign wdt_rst = sync2_r[2];
  assign pwr_lost = sync2_r[3];

  // State
  srt_ctrl_s ctrl_r;
  srt_regu_s regu_r;
  logic [31:0] sec_r;
  logic [31:0] alm_r;
  logic pd_r;
  srt_wr_e wst_r;
  logic [31:0] settle_r;
  logic [7:0] pend_addr_r;
  logic [31:0] pend_data_r;
  logic [16:0] cyc_r;
  logic [9:0] tcnt_r;
  logic tick_r;

  // Bus decode
  logic hit;
  logic access;
  logic wr_go;
  logic apply;
  logic slow_ok;
  logic [16:0] limit;
  logic [31:0] rd_nxt;
  logic land;
  logic sec_land;
  logic alm_land;
  logic reg_land;
  logic pwr_land;

  always_comb begin
    unique case (paddr)
      `SRT_OFF_CTRL,
      `SRT_OFF_SEC,
      `SRT_OFF_ALM,
      `SRT_OFF_REG,
      `SRT_OFF_PWR: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end

  assign access = psel & penable & pready;
  assign wr_go = access & pwrite & hit;
  // A write while another settles is dropped; software must poll first
  assign slow_ok = wr_go & (wst_r == SRT_WR_IDLE) & ~pd_r;
  assign apply = (wst_r == SRT_WR_SETTLE) && (settle_r == SETTLE_LAST);
  // Power loss mid-settle drops the word instead of letting it land
  assign land = apply & ~pd_r;
  assign sec_land = land && pend_addr_r == `SRT_OFF_SEC;
  assign alm_land = land && pend_addr_r == `SRT_OFF_ALM;
  assign reg_land = land && pend_addr_r == `SRT_OFF_REG;
  assign pwr_land = land && pend_addr_r == `SRT_OFF_PWR;

  // Answer one cycle after setup so every bus output is a flop
  // Reads latch at setup: prdata shows the value before the access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else if (psel && !penable) begin
      pready <= 1'b1;
      pslverr <= ~hit;
      prdata <= pwrite ? 32'h0 : rd_nxt;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  always_comb begin
    rd_nxt = 32'h0;
    unique case (paddr)
      `SRT_OFF_CTRL: begin
        rd_nxt[`SRT_B_RUN] = ctrl_r.run;
        rd_nxt[`SRT_B_AE] = ctrl_r.ae;
        rd_nxt[`SRT_B_AIE] = ctrl_r.alarm_irq_enable;
        rd_nxt[`SRT_B_AF] = ctrl_r.af;
        rd_nxt[`SRT_B_TIE] = ctrl_r.tie;
        rd_nxt[`SRT_B_TF] = ctrl_r.tf;
        rd_nxt[`SRT_B_WRITE_SETTLED_FLAG] = (wst_r == SRT_WR_IDLE);
      end
      `SRT_OFF_SEC: rd_nxt = sec_r;
      `SRT_OFF_ALM: rd_nxt = alm_r;
      `SRT_OFF_REG: begin
        rd_nxt[`SRT_B_LOCK] = regu_r.lock;
        rd_nxt[25:16] = regu_r.adj;
        rd_nxt[15:0] = regu_r.base;
      end
      `SRT_OFF_PWR: begin
        rd_nxt[0] = pd_r;
      end
      default: rd_nxt = 32'h0;
    endcase
  end

  // Slow write path: hold the word until it has settled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wst_r <= SRT_WR_IDLE;
      settle_r <= 32'h0;
      pend_addr_r <= 8'h0;
      pend_data_r <= 32'h0;
    end else if (hib_rst) begin
      // Hibernate reset discards a word still settling
      wst_r <= SRT_WR_IDLE;
      settle_r <= 32'h0;
    end else begin
      unique case (wst_r)
        SRT_WR_IDLE: begin
          settle_r <= 32'h0;
          if (slow_ok) begin
            wst_r <= SRT_WR_SETTLE;
            pend_addr_r <= paddr;
            pend_data_r <= pwdata;
          end
        end
        SRT_WR_SETTLE: begin
          settle_r <= settle_r + 32'h1;
          if (apply) begin
            wst_r <= SRT_WR_IDLE;
          end
        end
      endcase
    end
  end

  // Tick regulator; 17-bit count so the longest interval still ends
  logic long_ivl;
  logic ivl_end;

  assign long_ivl = tcnt_r < regu_r.adj;
  assign limit = {1'b0, regu_r.base} + {16'h0, long_ivl};
  assign ivl_end = edge32 && (cyc_r >= limit);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cyc_r <= 17'h0;
      tcnt_r <= 10'h0;
      tick_r <= 1'b0;
    end else begin
      tick_r <= ivl_end;
      if (ivl_end) begin
        cyc_r <= 17'h0;
        tcnt_r <= tcnt_r + 10'h1;
      end else if (edge32) begin
        cyc_r <= cyc_r + 17'h1;
      end
    end
  end

  // Regulator register: lock cleared by every reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      regu_r.lock <= 1'b0;
      regu_r.adj <= `SRT_ADJ_RST;
      regu_r.base <= `SRT_BASE_RST;
    end else if (hib_rst || wdt_rst) begin
      regu_r.lock <= 1'b0;
    end else if (reg_land && !regu_r.lock) begin
      regu_r.lock <= pend_data_r[`SRT_B_LOCK];
      regu_r.adj <= pend_data_r[25:16];
      regu_r.base <= pend_data_r[15:0];
    end
  end

  // Seconds and alarm keep their value across every reset
  always_ff @(posedge pclk) begin
    if (sec_land) begin
      sec_r <= pend_data_r;
    end else if (tick_r && ctrl_r.run) begin
      sec_r <= sec_r + 32'h1;
    end
  end

  always_ff @(posedge pclk) begin
    if (alm_land) begin
      alm_r <= pend_data_r;
    end
  end

  // Control register; watchdog reset leaves it alone
  logic ctl_wr;
  logic ctl_apply;
  logic alarm_hit;
  logic af_clr;
  logic tf_clr;

  assign ctl_wr = wr_go && paddr == `SRT_OFF_CTRL;
  assign ctl_apply = land && pend_addr_r == `SRT_OFF_CTRL;
  assign alarm_hit = (sec_r == alm_r) & ctrl_r.ae & ctrl_r.run;
  // Flag clears bypass the settle path; power-down blocks alarm flag clears but not sets
  assign af_clr = ctl_wr && !pd_r && !pwdata[`SRT_B_AF];
  assign tf_clr = ctl_wr && !pwdata[`SRT_B_TF];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r.run <= CTRL_RST[`SRT_B_RUN];
      ctrl_r.ae <= CTRL_RST[`SRT_B_AE];
      ctrl_r.alarm_irq_enable <= CTRL_RST[`SRT_B_AIE];
    end else if (hib_rst) begin
      ctrl_r.run <= CTRL_RST[`SRT_B_RUN];
      ctrl_r.ae <= CTRL_RST[`SRT_B_AE];
      ctrl_r.alarm_irq_enable <= CTRL_RST[`SRT_B_AIE];
    end else if (ctl_apply) begin
      ctrl_r.run <= pend_data_r[`SRT_B_RUN];
      ctrl_r.ae <= pend_data_r[`SRT_B_AE];
      ctrl_r.alarm_irq_enable <= pend_data_r[`SRT_B_AIE];
    end
  end

  // Flag bits: writes take effect at once, a set beats a clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r.af <= CTRL_RST[`SRT_B_AF];
      ctrl_r.tf <= CTRL_RST[`SRT_B_TF];
      ctrl_r.tie <= CTRL_RST[`SRT_B_TIE];
    end else if (hib_rst) begin
      ctrl_r.af <= CTRL_RST[`SRT_B_AF];
      ctrl_r.tf <= CTRL_RST[`SRT_B_TF];
      ctrl_r.tie <= CTRL_RST[`SRT_B_TIE];
    end else begin
      if (alarm_hit) begin
        ctrl_r.af <= 1'b1;
      end else if (af_clr) begin
        ctrl_r.af <= 1'b0;
      end
      if (tick_r && ctrl_r.run) begin
        ctrl_r.tf <= 1'b1;
      end else if (tf_clr) begin
        ctrl_r.tf <= 1'b0;
      end
      if (ctl_wr) begin
        ctrl_r.tie <= pwdata[`SRT_B_TIE];
      end
    end
  end

  // Power-down bit; watchdog reset does not clear it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pd_r <= 1'b0;
    end else if (pwr_lost) begin
      // Loss beats a hibernate clear: the supply is still down
      pd_r <= 1'b1;
    end else if (hib_rst) begin
      pd_r <= 1'b0;
    end else if (pwr_land) begin
      pd_r <= pend_data_r[0];
    end
  end

  // Pin outputs from flops
  logic alarm_irq;
  logic tick_irq;

  assign alarm_irq = ctrl_r.af & ctrl_r.alarm_irq_enable;
  assign tick_irq = ctrl_r.tf & ctrl_r.tie;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      main_power_on_output <= 1'b0;
      rtc_irq <= 1'b0;
    end else begin
      main_power_on_output <= pd_r;
      rtc_irq <= alarm_irq | tick_irq;
    end
  end

endmodule
`default_nettype wire

// *** srt_cfg.svh ***
// Register map, field positions, reset values and timing counts
//
// Functional notes
// - Control bit 2 enables alarm matching; 0 turns the alarm off.
// - Control bit 0 runs timekeeping; 0 stops it.
// - Reserved bits ignore writes and read as zero.
// - Seconds count is 32-bit RW, +1 per tick while run enable is 1.
// - No reset touches the seconds count.
// - Alarm flag sets when seconds equal alarm with alarm and run enabled.
// - Seconds alarm is RW and never reset.
// - Regulator bit 31 locks the register; software alone sets it.
// - Every reset type clears the regulator lock.
// - Regulator bits 15:0 give base; tick every base+1 slow cycles.
// - Bits 25:16 give adjust; that many of 1024 intervals last base+2.
// - Power bit 0 drives the power output; 1 means main power off.
// - Device sets the power-down bit itself on unexplained power loss.
// - While powered down, only tick flag and tick enable accept writes.
// - Pad reset and hibernate reset clear the power-down bit.
// - Writes settle in 35 to 65 us; settled flag reads 0 meanwhile.
// - Control bit 6 sets per tick while running; writing 0 clears it.
// - Control bit 3 raises the interrupt while the alarm flag is set.
`ifndef SRT_CFG_SVH
`define SRT_CFG_SVH

`define SRT_OFF_CTRL 8'h00
`define SRT_OFF_SEC 8'h04
`define SRT_OFF_ALM 8'h08
`define SRT_OFF_REG 8'h0c
`define SRT_OFF_PWR 8'h20

`define SRT_B_RUN 0
`define SRT_B_AE 2
`define SRT_B_AIE 3
`define SRT_B_AF 4
`define SRT_B_TIE 5
`define SRT_B_TF 6
`define SRT_B_WRITE_SETTLED_FLAG 7
`define SRT_B_LOCK 31

`define SRT_CTRL_RST 32'h00000081
`define SRT_BASE_RST 16'h7fff
`define SRT_ADJ_RST 10'h000

`define SRT_CLK_NS 8
`define SRT_SETTLE_US 35
`define SRT_SETTLE_CYC ((`SRT_SETTLE_US * 1000 + `SRT_CLK_NS - 1) / `SRT_CLK_NS)

`endif

// *** srt_pkg.sv ***
// Types shared by the seconds clock block
package srt_pkg;

  typedef struct packed {
    logic lock;
    logic [9:0] adj;
    logic [15:0] base;
  } srt_regu_s;

  typedef struct packed {
    logic tf;
    logic tie;
    logic af;
    logic alarm_irq_enable;
    logic ae;
    logic run;
  } srt_ctrl_s;

  typedef enum logic [1:0] {
    SRT_WR_IDLE = 2'b01,
    SRT_WR_SETTLE = 2'b10
  } srt_wr_e;

endpackage

// *** srt_top_assertions.sv ***
// Port checks for the seconds clock block
`timescale 1ns/100ps
`default_nettype none
module srt_top_chk (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Pins
  input wire logic clk_32k,
  input wire logic hib_reset_n,
  input wire logic wdt_reset_n,
  input wire logic main_power_lost,
  input wire logic main_power_on_output,
  input wire logic rtc_irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_err_map: assert property (
    pready |-> pslverr == !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h20}))
    else $error("bad error flag");
  chk_ctrl_rsvd: assert property (
    pready && !pwrite && paddr == 8'h00 |-> !prdata[1] && prdata[31:8] == 0)
    else $error("ctrl reserved set");
  chk_pwr_rsvd: assert property (
    pready && !pwrite && paddr == 8'h20 |-> prdata[31:1] == 0)
    else $error("power reserved set");
  chk_pin_follow: assert property (
    pready && !pwrite && paddr == 8'h20 |-> main_power_on_output == prdata[0])
    else $error("pin differs from bit");
  chk_lost_sets: assert property (
    $rose(main_power_lost) |-> ##[1:8] main_power_on_output)
    else $error("loss not seen");
  chk_hib_clears: assert property (
    (!hib_reset_n && !main_power_lost) [*6] |=> !main_power_on_output)
    else $error("hibernate reset kept power off");
  chk_settle_low: assert property (
    pready && pwrite && paddr == 8'h04 && !main_power_on_output ##2
    psel && !penable && paddr == 8'h00 ##1 pready |-> !prdata[7])
    else $error("settled flag high too soon");
  chk_alarm_irq: assert property (
    pready && !pwrite && paddr == 8'h00 && prdata[4] && prdata[3]
    |-> ##[0:2] rtc_irq)
    else $error("alarm irq missing");
  cov_write: cover property (pready && pwrite);
  cov_err: cover property (pready && pslverr);
  cov_irq: cover property ($rose(rtc_irq));
endmodule
bind srt_top srt_top_chk u_srt_top_chk (.*);
`default_nettype wire

// *** srt_power_switch.sv ***
// Model of the switch feeding the main supply
`timescale 1ns/100ps
`default_nettype none
module srt_power_switch (
  // From the block
  input wire logic main_power_on_output,
  // Bench command
  input wire logic drop,
  // Supply state
  output logic supply_on,
  output logic main_power_lost
);
  assign supply_on = !main_power_on_output;
  // Loss only on command, so the block sees a drop it did not order
  assign main_power_lost = drop;
endmodule
`default_nettype wire

// *** tb_top.sv ***
// Self-checking bench for the seconds clock block
`timescale 1ns/100ps
`default_nettype none
`define CHK(n,e,g) begin comparisons++; if ((g) !== (e)) begin err_count++; \
  $display("FAIL %s exp %h got %h", n, e, g); end end
module tb_top;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic clk_32k = 0, hib_reset_n = 1, wdt_reset_n = 1, drop = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd, t, prev;
  logic pready, pslverr, er, rtc_irq, main_power_on_output;
  logic main_power_lost, supply_on;
  int err_count = 0, comparisons = 0, cyc = 0, i;
  int seed = 32'h2f16fd8e;
  srt_top #(.SETTLE_CYC(4)) u_srt_top (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .clk_32k(clk_32k),
    .hib_reset_n(hib_reset_n), .wdt_reset_n(wdt_reset_n),
    .main_power_lost(main_power_lost),
    .main_power_on_output(main_power_on_output), .rtc_irq(rtc_irq));
  srt_power_switch u_srt_power_switch (
    .main_power_on_output(main_power_on_output), .drop(drop),
    .supply_on(supply_on), .main_power_lost(main_power_lost));
  initial forever #4 pclk = ~pclk;
  // Slow pin toggled every fourth bus edge: eight bus cycles a period
  initial forever begin
    repeat (4) @(posedge pclk);
    clk_32k <= ~clk_32k;
  end
  task end_of_test;
    $display("checks %0d errors %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 40000) begin
      err_count++;
      end_of_test;
    end
  end
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  task rdc(input logic [7:0] a);
    xfer(0, a, 32'h0);
  endtask
  // Writes issued mid-settle are dropped, so always poll first
  task settle;
    do rdc(8'h00); while (rd[7] !== 1'b1);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    settle;
    xfer(1, a, d);
  endtask
  task waitn(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // Ticks in 200 slow cycles for a given base and adjust
  function int exp_t(int b, int a);
    return 204800 / ((b + 1) * 1024 + a);
  endfunction
  // Seconds are taken only when two reads in a row agree
  task rsec;
    do begin
      rdc(8'h04);
      prev = rd;
      rdc(8'h04);
    end while (rd !== prev);
  endtask
  task rate(input int b, input int a);
    settle;
    rsec;
    t = rd;
    waitn(1600);
    rsec;
    `CHK("rate", 1'b1, (rd - t - exp_t(b, a) + 1) <= 2)
  endtask
  initial begin
    waitn(20);
    presetn <= 1;
    rdc(8'h00);
    `CHK("ctrl", 32'h81, rd)
    rdc(8'h0c);
    `CHK("regu", 32'h7fff, rd)
    rdc(8'h10);
    `CHK("err", 1'b1, er)
    wr(8'h00, 32'h2);
    wr(8'h0c, 32'h7c000003);
    settle;
    `CHK("ctrl", 32'h80, rd)
    rdc(8'h0c);
    `CHK("regu", 32'h3, rd)
    for (i = 0; i < 3; i++) begin
      t = $random(seed);
      wr(8'h04, t);
      wr(8'h08, ~t);
      settle;
      rdc(8'h04);
      `CHK("sec", t, rd)
      rdc(8'h08);
      `CHK("alm", ~t, rd)
    end
    waitn(200);
    rdc(8'h04);
    `CHK("stop", t, rd)
    wr(8'h00, 32'h1);
    rate(3, 0);
    wr(8'h0c, 32'h03ff0003);
    rate(3, 1023);
    rdc(8'h00);
    `CHK("tf", 1'b1, rd[6])
    wr(8'h00, 32'h21);
    waitn(80);
    `CHK("irq", 1'b1, rtc_irq)
    wr(8'h00, 32'h01);
    waitn(8);
    `CHK("irq", 1'b0, rtc_irq)
    rdc(8'h04);
    wr(8'h08, rd + 3);
    wr(8'h00, 32'h0d);
    waitn(400);
    rdc(8'h00);
    `CHK("af", 1'b1, rd[4])
    `CHK("irq", 1'b1, rtc_irq)
    wr(8'h00, 32'h09);
    rdc(8'h04);
    wr(8'h08, rd + 3);
    waitn(400);
    rdc(8'h00);
    `CHK("af", 1'b0, rd[4])
    wr(8'h0c, 32'h80000003);
    wr(8'h0c, 32'h5);
    settle;
    rdc(8'h0c);
    `CHK("lock", 32'h80000003, rd)
    wdt_reset_n <= 0;
    waitn(6);
    wdt_reset_n <= 1;
    waitn(6);
    rdc(8'h0c);
    `CHK("lock", 32'h3, rd)
    wr(8'h20, 32'hffffffff);
    settle;
    rdc(8'h20);
    `CHK("pd", 32'h1, rd)
    `CHK("pin", 2'b10, {main_power_on_output, supply_on})
    rdc(8'h04);
    t = rd;
    wr(8'h04, ~t);
    settle;
    rdc(8'h04);
    `CHK("pdwr", 1'b1, (rd - t) <= 1)
    hib_reset_n <= 0;
    waitn(6);
    hib_reset_n <= 1;
    waitn(6);
    `CHK("pin", 1'b0, main_power_on_output)
    drop <= 1;
    waitn(8);
    `CHK("pin", 1'b1, main_power_on_output)
    drop <= 0;
    rdc(8'h04);
    t = rd;
    presetn <= 0;
    waitn(4);
    presetn <= 1;
    waitn(2);
    `CHK("pin", 1'b0, main_power_on_output)
    rdc(8'h04);
    `CHK("keep", 1'b1, (rd - t) <= 1)
    end_of_test;
  end
endmodule
`default_nettype wire
